// >>> core/tcdc_filter.v
// glitch filter that accepts a new input level only after it holds steady
`timescale 1ns/100ps
`include "tcdc_regs.vh"

module tcdc_filter (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // filter choice and level
  input wire [1:0] filter_sel_in,
  input wire level_in,
  // filtered level
  output reg level_out
);

  reg [3:0] stable_q;
  reg [3:0] need;

  // required stable length for the chosen filter
  always @* begin
    case (filter_sel_in)
      `TCDC_FLT_SHORT: need = `TCDC_FLT_SHORT_CYC;
      `TCDC_FLT_LONG: need = `TCDC_FLT_LONG_CYC;
      default: need = `TCDC_FLT_NONE_CYC;
    endcase
  end

  // count cycles the differing level has held
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stable_q <= 4'h0;
      level_out <= 1'b0;
    end else if (level_in == level_out) begin
      stable_q <= 4'h0;
    end else if (stable_q + 4'h1 >= need) begin
      level_out <= level_in; // [RL19]
      stable_q <= 4'h0;
    end else begin
      stable_q <= stable_q + 4'h1;
    end
  end

endmodule

// >>> core/tcdc_regs.vh
// register map, field positions and reset values of the timer capture block
`ifndef TCDC_REGS_VH
`define TCDC_REGS_VH

// bank selection pointer, reached at its full address
`define TCDC_RP_ADDR 8'hfd
`define TCDC_RP_RESET 8'h00

// expanded bank numbers
`define TCDC_BANK_NORMAL 4'h0
`define TCDC_BANK_TIMER 4'hd
`define TCDC_BANK_SYSTEM 4'hf

// timer bank register indexes
`define TCDC_IDX_CTRL 4'h1
`define TCDC_IDX_RELOAD_HI 4'h7
`define TCDC_IDX_WIDE_CAP_LO 4'h8
`define TCDC_IDX_WIDE_CAP_HI 4'h9
`define TCDC_IDX_NARROW_CAP_LO 4'ha
`define TCDC_IDX_NARROW_CAP_HI 4'hb

// control field positions
`define TCDC_CTRL_MODE 7
`define TCDC_CTRL_ROUTE 6
`define TCDC_CTRL_LOGIC_HI 5
`define TCDC_CTRL_LOGIC_LO 4
`define TCDC_CTRL_SUB_HI 3
`define TCDC_CTRL_SUB_LO 2
`define TCDC_CTRL_NARROW 1
`define TCDC_CTRL_WIDE 0
`define TCDC_CTRL_RESET 8'h00

// transmit submodes
`define TCDC_SUB_NORMAL 2'h0
`define TCDC_SUB_PINGPONG 2'h1
`define TCDC_SUB_FORCE_LO 2'h2
`define TCDC_SUB_FORCE_HI 2'h3

// glitch filter choices and their lengths in system clocks
`define TCDC_FLT_NONE 2'h0
`define TCDC_FLT_NONE_CYC 4'h1
`define TCDC_FLT_SHORT 2'h1
`define TCDC_FLT_LONG 2'h2
`define TCDC_FLT_SHORT_CYC 4'h4
`define TCDC_FLT_LONG_CYC 4'h8

// timer output combine functions
`define TCDC_LOGIC_AND 2'h0
`define TCDC_LOGIC_OR 2'h1
`define TCDC_LOGIC_NOR 2'h2
`define TCDC_LOGIC_NAND 2'h3

// demodulation edge choices
`define TCDC_EDGE_FALL 2'h0
`define TCDC_EDGE_RISE 2'h1
`define TCDC_EDGE_BOTH 2'h2

`endif

// >>> core/tcdc_top.v
// bank pointer, common control and capture registers of the timer pair
`timescale 1ns/100ps
`include "tcdc_regs.vh"

// Notes on behaviour
// (RL1) pointer high nibble picks the 16-byte working group for short addresses
// (RL2) pointer low nibble zero leaves the low sixteen addresses on bank zero
// (RL3) nonzero low nibble swaps the low sixteen addresses to that bank
// (RL4) only banks 0, F and D exist; timer registers live in bank D
// (RL5) narrow high capture holds the count taken while input was one
// (RL6) narrow low capture holds the count taken while input was zero
// (RL7) both narrow captures load from the narrow counter output
// (RL8) wide capture splits into a high byte and a low byte register
// (RL9) writes leave the capture registers unchanged; reads return captures
// (RL10) bits 3:2 pick transmit submode or demodulation glitch filter
// (RL11) transmit bit 1 gives the narrow output initial level, zero default
// (RL12) demodulation bit 1 is the rising edge flag, write one clears
// (RL13) transmit bit 0 gives the wide output initial level, zero default
// (RL14) demodulation bit 0 is the falling edge flag, write one clears
// (RL15) mode bit zero means transmit, one means demodulation
// (RL16) transmit routing bit puts combined timer output on shared pin
// (RL17) demodulation routing bit picks which input pin is measured
// (RL18) port3 input captures also raise interrupt request two
// (RL19) filter accepts a level only after it stays stable long enough
module tcdc_top (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // cpu register access
  input wire [7:0] reg_addr_in,
  input wire reg_short_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  output reg reg_hit_out,
  // address mapping toward the register file
  output reg [7:0] map_addr_out,
  output reg [3:0] map_bank_out,
  output reg map_expanded_out,
  output reg map_valid_out,
  // counting engines
  input wire [7:0] narrow_count_in,
  input wire [15:0] wide_count_in,
  input wire narrow_timer_output_in,
  input wire wide_timer_output_in,
  output reg capture_event_out,
  output reg demod_mode_out,
  output reg [1:0] transmit_submode_out,
  output reg narrow_init_level_out,
  output reg wide_init_level_out,
  output reg [7:0] wide_timer_reload_high_out,
  // pins
  input wire port3_demod_input_pin_in,
  input wire alternate_demod_input_pin_in,
  input wire port_data_in,
  output reg shared_timer_output_pin_out,
  output reg shared_timer_output_pin_oe_out,
  output reg interrupt_request_two_out
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // full register address of an access
  function [7:0] tcdc_full_addr;
    input [7:0] addr;
    input short;
    input [7:0] rp;
    begin
      if (short)
        tcdc_full_addr = {rp[7:4], addr[3:0]}; // [RL1]
      else
        tcdc_full_addr = addr;
    end
  endfunction

  // true when the full address lands in a swapped expanded bank
  function tcdc_is_expanded;
    input [7:0] full;
    input [7:0] rp;
    begin
      tcdc_is_expanded = (full[7:4] == 4'h0) &&
        (rp[3:0] != `TCDC_BANK_NORMAL); // [RL2] [RL3]
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] rp_q;
  reg [7:0] ctrl_q;
  reg narrow_init_q;
  reg wide_init_q;
  reg rise_flag_q;
  reg fall_flag_q;
  reg [7:0] reload_hi_q;
  reg [7:0] wide_cap_lo_q;
  reg [7:0] wide_cap_hi_q;
  reg [7:0] narrow_cap_lo_q;
  reg [7:0] narrow_cap_hi_q;

  // pin synchronisers and edge history
  reg p3_meta_q;
  reg p3_sync_q;
  reg alt_meta_q;
  reg alt_sync_q;
  reg demod_prev_q;

  wire [7:0] full_addr;
  wire expanded;
  wire timer_bank;
  wire rp_hit;
  wire demod;
  wire route;
  wire [1:0] logic_sel;
  wire [1:0] sub_sel;
  wire demod_raw;
  wire demod_level;
  wire rise;
  wire fall;
  wire ctrl_wr;
  wire clear_rise;
  wire clear_fall;
  reg capture;
  reg wide_eff;
  reg combined;
  reg [7:0] rdata;
  reg hit;

  //////////////////////////////////////////////////////////////////////////
  // address decode

  assign full_addr = tcdc_full_addr(reg_addr_in, reg_short_in, rp_q);
  assign expanded = tcdc_is_expanded(full_addr, rp_q);
  // only bank D is served here; 0 and F belong to other blocks
  assign timer_bank = expanded && (rp_q[3:0] == `TCDC_BANK_TIMER); // [RL4]
  assign rp_hit = (full_addr == `TCDC_RP_ADDR);
  assign ctrl_wr = reg_wr_in && timer_bank &&
    (full_addr[3:0] == `TCDC_IDX_CTRL);

  // control fields
  assign demod = ctrl_q[`TCDC_CTRL_MODE]; // [RL15]
  assign route = ctrl_q[`TCDC_CTRL_ROUTE];
  assign logic_sel = ctrl_q[`TCDC_CTRL_LOGIC_HI:`TCDC_CTRL_LOGIC_LO];
  assign sub_sel = ctrl_q[`TCDC_CTRL_SUB_HI:`TCDC_CTRL_SUB_LO];

  // write one clears a flag only in demodulation mode
  assign clear_rise = ctrl_wr && demod && reg_wdata_in[`TCDC_CTRL_NARROW];
  assign clear_fall = ctrl_wr && demod && reg_wdata_in[`TCDC_CTRL_WIDE];

  //////////////////////////////////////////////////////////////////////////
  // demodulation input path

  // two-stage synchronisers on both candidate input pins
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      p3_meta_q <= 1'b0;
      p3_sync_q <= 1'b0;
      alt_meta_q <= 1'b0;
      alt_sync_q <= 1'b0;
    end else begin
      p3_meta_q <= port3_demod_input_pin_in;
      p3_sync_q <= p3_meta_q;
      alt_meta_q <= alternate_demod_input_pin_in;
      alt_sync_q <= alt_meta_q;
    end
  end

  // routing bit picks the measured pin
  assign demod_raw = route ? alt_sync_q : p3_sync_q; // [RL17]

  // glitch filter, choice from bits 3:2 in demodulation mode
  tcdc_filter u_filter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .filter_sel_in(sub_sel), // [RL10]
    .level_in(demod_raw),
    .level_out(demod_level)
  );

  // edge history of the filtered level
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in)
      demod_prev_q <= 1'b0;
    else
      demod_prev_q <= demod_level;
  end

  assign rise = demod && demod_level && !demod_prev_q;
  assign fall = demod && !demod_level && demod_prev_q;

  // capture on the selected edge kind
  always @* begin
    case (logic_sel)
      `TCDC_EDGE_FALL: capture = fall;
      `TCDC_EDGE_RISE: capture = rise;
      `TCDC_EDGE_BOTH: capture = rise || fall;
      default: capture = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // capture registers, loaded only by hardware

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      narrow_cap_lo_q <= 8'h00;
      narrow_cap_hi_q <= 8'h00;
      wide_cap_lo_q <= 8'h00;
      wide_cap_hi_q <= 8'h00;
    end else if (capture) begin
      // the level that just ended decides high or low capture
      if (demod_prev_q)
        narrow_cap_hi_q <= narrow_count_in; // [RL5] [RL7]
      else
        narrow_cap_lo_q <= narrow_count_in; // [RL6] [RL7]
      wide_cap_hi_q <= wide_count_in[15:8]; // [RL8]
      wide_cap_lo_q <= wide_count_in[7:0]; // [RL8]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // software written registers

  // pointer, control, initial levels and reload byte
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rp_q <= `TCDC_RP_RESET;
      ctrl_q <= `TCDC_CTRL_RESET;
      narrow_init_q <= 1'b0; // [RL11]
      wide_init_q <= 1'b0; // [RL13]
      reload_hi_q <= 8'h00;
    end else if (reg_wr_in) begin
      if (rp_hit)
        rp_q <= reg_wdata_in;
      if (ctrl_wr) begin
        ctrl_q <= reg_wdata_in;
        // initial levels are taken while transmit mode is active
        if (!demod) begin
          narrow_init_q <= reg_wdata_in[`TCDC_CTRL_NARROW]; // [RL11]
          wide_init_q <= reg_wdata_in[`TCDC_CTRL_WIDE]; // [RL13]
        end
      end
      if (timer_bank && full_addr[3:0] == `TCDC_IDX_RELOAD_HI)
        reload_hi_q <= reg_wdata_in;
    end
  end

  // edge flags: a new edge wins over a clear in the same cycle
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end else begin
      if (rise)
        rise_flag_q <= 1'b1; // [RL12]
      else if (clear_rise)
        rise_flag_q <= 1'b0; // [RL12]
      if (fall)
        fall_flag_q <= 1'b1; // [RL14]
      else if (clear_fall)
        fall_flag_q <= 1'b0; // [RL14]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data

  always @* begin
    rdata = 8'h00;
    hit = 1'b0;
    if (rp_hit) begin
      rdata = rp_q;
      hit = 1'b1;
    end else if (timer_bank) begin
      hit = 1'b1;
      case (full_addr[3:0])
        `TCDC_IDX_CTRL: begin
          rdata = ctrl_q;
          // low two bits show flags or initial levels by mode
          rdata[`TCDC_CTRL_NARROW] = demod ? rise_flag_q :
            narrow_init_q; // [RL12]
          rdata[`TCDC_CTRL_WIDE] = demod ? fall_flag_q :
            wide_init_q; // [RL14]
        end
        `TCDC_IDX_RELOAD_HI: rdata = reload_hi_q;
        `TCDC_IDX_WIDE_CAP_LO: rdata = wide_cap_lo_q; // [RL9]
        `TCDC_IDX_WIDE_CAP_HI: rdata = wide_cap_hi_q; // [RL9]
        `TCDC_IDX_NARROW_CAP_LO: rdata = narrow_cap_lo_q; // [RL9]
        `TCDC_IDX_NARROW_CAP_HI: rdata = narrow_cap_hi_q; // [RL9]
        default: rdata = 8'h00;
      endcase
    end
  end

  // registered answer and mapped address
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
      reg_hit_out <= 1'b0;
      map_addr_out <= 8'h00;
      map_bank_out <= 4'h0;
      map_expanded_out <= 1'b0;
      map_valid_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata : 8'h00;
      reg_hit_out <= (reg_rd_in || reg_wr_in) && hit;
      map_valid_out <= reg_rd_in || reg_wr_in;
      map_addr_out <= full_addr; // [RL1]
      map_expanded_out <= expanded; // [RL3]
      map_bank_out <= expanded ? rp_q[3:0] : `TCDC_BANK_NORMAL; // [RL2]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit output path

  // forced submodes override the wide timer output
  always @* begin
    case (sub_sel)
      `TCDC_SUB_FORCE_LO: wide_eff = 1'b0; // [RL10]
      `TCDC_SUB_FORCE_HI: wide_eff = 1'b1; // [RL10]
      default: wide_eff = wide_timer_output_in;
    endcase
  end

  // combine both timer outputs
  always @* begin
    case (logic_sel)
      `TCDC_LOGIC_AND: combined = narrow_timer_output_in & wide_eff;
      `TCDC_LOGIC_OR: combined = narrow_timer_output_in | wide_eff;
      `TCDC_LOGIC_NOR: combined = ~(narrow_timer_output_in | wide_eff);
      `TCDC_LOGIC_NAND: combined = ~(narrow_timer_output_in & wide_eff);
      default: combined = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // engine and pin outputs

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      shared_timer_output_pin_out <= 1'b0;
      shared_timer_output_pin_oe_out <= 1'b0;
      capture_event_out <= 1'b0;
      interrupt_request_two_out <= 1'b0;
      demod_mode_out <= 1'b0;
      transmit_submode_out <= `TCDC_SUB_NORMAL;
      narrow_init_level_out <= 1'b0;
      wide_init_level_out <= 1'b0;
      wide_timer_reload_high_out <= 8'h00;
    end else begin
      // shared pin: port data or combined timers in transmit mode
      shared_timer_output_pin_out <= route ? combined :
        port_data_in; // [RL16]
      shared_timer_output_pin_oe_out <= !demod; // [RL16]
      capture_event_out <= capture;
      // port3 sourced captures request interrupt two; masking is outside
      interrupt_request_two_out <= capture && !route; // [RL18]
      demod_mode_out <= demod; // [RL15]
      transmit_submode_out <= demod ? `TCDC_SUB_NORMAL : sub_sel; // [RL10]
      narrow_init_level_out <= narrow_init_q;
      wide_init_level_out <= wide_init_q;
      wide_timer_reload_high_out <= reload_hi_q;
    end
  end

endmodule

// >>> dv/tb.sv
// self-checking bench for the timer capture block
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic wr;
    logic sh;
    logic [7:0] a;
    logic [7:0] d;
    logic hit;
  } tcdc_row_t;
  // design side signals
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_short_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] narrow_count_in = 8'h00;
  logic [15:0] wide_count_in = 16'h0000;
  logic port_data_in = 1'b0;
  logic narrow_tout = 1'b0;
  logic wide_tout = 1'b0;
  wire [7:0] reg_rdata_out, map_addr_out, wide_timer_reload_high_out;
  wire [3:0] map_bank_out;
  wire [1:0] transmit_submode_out;
  wire reg_hit_out, map_expanded_out, map_valid_out, capture_event_out;
  wire demod_mode_out, narrow_init_level_out, wide_init_level_out;
  wire shared_timer_output_pin_out, shared_timer_output_pin_oe_out;
  wire interrupt_request_two_out, p3_pin, alt_pin;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  // access rows: write flag, short, address, data or expected, hit
  tcdc_row_t rows [18] = '{
    {1'b0,1'b0,8'hfd,8'h00,1'b1}, {1'b1,1'b0,8'hfd,8'h0d,1'b1},
    {1'b0,1'b0,8'hfd,8'h0d,1'b1}, {1'b0,1'b0,8'h01,8'h00,1'b1},
    {1'b1,1'b0,8'h07,8'ha5,1'b1}, {1'b0,1'b0,8'h07,8'ha5,1'b1},
    {1'b0,1'b0,8'h0c,8'h00,1'b1}, {1'b0,1'b0,8'h40,8'h00,1'b0},
    {1'b1,1'b0,8'h08,8'hff,1'b1}, {1'b0,1'b0,8'h08,8'h00,1'b1},
    {1'b1,1'b0,8'hfd,8'h0f,1'b1}, {1'b0,1'b0,8'h01,8'h00,1'b0},
    {1'b1,1'b0,8'hfd,8'hd0,1'b1}, {1'b0,1'b1,8'h01,8'h00,1'b0},
    {1'b1,1'b0,8'hfd,8'h1d,1'b1}, {1'b0,1'b1,8'h07,8'h00,1'b0},
    {1'b1,1'b0,8'hfd,8'h0d,1'b1}, {1'b0,1'b1,8'h07,8'ha5,1'b1}};

  tcdc_top tcdc_top_i (.clk_in, .reset_in, .reg_addr_in, .reg_short_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_hit_out,
    .map_addr_out, .map_bank_out, .map_expanded_out, .map_valid_out,
    .narrow_count_in, .wide_count_in, .narrow_timer_output_in(narrow_tout),
    .wide_timer_output_in(wide_tout), .capture_event_out, .demod_mode_out,
    .transmit_submode_out, .narrow_init_level_out, .wide_init_level_out,
    .wide_timer_reload_high_out, .port3_demod_input_pin_in(p3_pin),
    .alternate_demod_input_pin_in(alt_pin), .port_data_in,
    .shared_timer_output_pin_out, .shared_timer_output_pin_oe_out,
    .interrupt_request_two_out);
  tcdc_pin_model tcdc_pin_model_i (.clk_in, .port3_pin_out(p3_pin),
    .alt_pin_out(alt_pin));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  // compare seen against expected
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access, strobe held for one taking edge
  task acc(input logic wr, input logic sh, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_in = a;
    reg_short_in = sh;
    reg_wdata_in = d;
    reg_wr_in = wr;
    reg_rd_in = !wr;
    @(posedge clk_in);
    #1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
  endtask
  // full address read and compare
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b0, a, 8'h00);
    check(reg_rdata_out, exp);
  endtask
  // bounded wait for a capture pulse
  task wait_cap(input logic irq);
    int k;
    for (k = 0; k < 16 && capture_event_out !== 1'b1; k++) begin
      @(posedge clk_in) #1;
    end
    check(capture_event_out, 1'b1);
    check(interrupt_request_two_out, irq);
  endtask
  // counts and verdict
  task summarize;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    check(demod_mode_out, 1'b0);
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].sh, rows[i].a, rows[i].d);
      if (!rows[i].wr) check(reg_rdata_out, rows[i].d);
      check(reg_hit_out, rows[i].hit);
    end
    // last row: short index 7 through pointer 0d, mapping and reload copy
    check({map_valid_out, map_expanded_out, map_bank_out, map_addr_out},
      16'h3d07);
    check(wide_timer_reload_high_out, 8'ha5);
    // transmit settings and shared pin routing
    acc(1'b1, 1'b0, 8'h01, 8'h4f);
    rdc(8'h01, 8'h4f);
    check(transmit_submode_out, 2'h3);
    check({narrow_init_level_out, wide_init_level_out}, 2'h3);
    check(shared_timer_output_pin_oe_out, 1'b1);
    // and of narrow output with forced-high wide output on the shared pin
    narrow_tout = 1'b1;
    @(posedge clk_in);
    #1;
    check(shared_timer_output_pin_out, 1'b1);
    // nor with wide output forced low despite a high engine output
    narrow_tout = 1'b0;
    wide_tout = 1'b1;
    acc(1'b1, 1'b0, 8'h01, 8'h68);
    @(posedge clk_in);
    #1;
    check(shared_timer_output_pin_out, 1'b1);
    acc(1'b1, 1'b0, 8'h01, 8'h04);
    port_data_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check(shared_timer_output_pin_out, 1'b1);
    // demodulation on port3 pin, no filter, falling capture
    narrow_count_in = 8'h3c;
    wide_count_in = 16'h1234;
    acc(1'b1, 1'b0, 8'h01, 8'h80);
    tcdc_pin_model_i.drive(1'b0, 1'b1, 6);
    rdc(8'h01, 8'h82);
    acc(1'b1, 1'b0, 8'h01, 8'h80);
    rdc(8'h01, 8'h82);
    acc(1'b1, 1'b0, 8'h01, 8'h82);
    rdc(8'h01, 8'h80);
    tcdc_pin_model_i.drive(1'b0, 1'b0, 0);
    wait_cap(1'b1);
    rdc(8'h0b, 8'h3c);
    rdc(8'h09, 8'h12);
    rdc(8'h08, 8'h34);
    rdc(8'h01, 8'h81);
    acc(1'b1, 1'b0, 8'h01, 8'h81);
    rdc(8'h01, 8'h80);
    // alternate pin, short filter, rising capture
    acc(1'b1, 1'b0, 8'h01, 8'hd4);
    tcdc_pin_model_i.drive(1'b1, 1'b1, 2);
    tcdc_pin_model_i.drive(1'b1, 1'b0, 8);
    rdc(8'h01, 8'hd4);
    narrow_count_in = 8'h5a;
    tcdc_pin_model_i.drive(1'b1, 1'b1, 0);
    wait_cap(1'b0);
    rdc(8'h0a, 8'h5a);
    rdc(8'h01, 8'hd6);
    // long filter rejects a short low glitch
    acc(1'b1, 1'b0, 8'h01, 8'hd8);
    tcdc_pin_model_i.drive(1'b1, 1'b0, 5);
    tcdc_pin_model_i.drive(1'b1, 1'b1, 10);
    rdc(8'h01, 8'hda);
    // reset in mid-run
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    check(demod_mode_out, 1'b0);
    rdc(8'hfd, 8'h00);
    acc(1'b1, 1'b0, 8'hfd, 8'h0d);
    rdc(8'h01, 8'h00);
    summarize();
  end
endmodule

bind tcdc_top tcdc_chk tcdc_chk_i (.clk_in, .reset_in, .reg_addr_in,
  .reg_short_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_hit_out,
  .map_addr_out, .map_bank_out, .map_expanded_out, .map_valid_out,
  .capture_event_out, .demod_mode_out, .transmit_submode_out,
  .shared_timer_output_pin_oe_out, .interrupt_request_two_out);

// >>> dv/tcdc_pin_model.sv
// far side model driving the two demodulator input pins
`timescale 1ns/100ps
module tcdc_pin_model (
  // clock
  input wire clk_in,
  // modelled signal pins
  output reg port3_pin_out,
  output reg alt_pin_out
);
  // both pins idle low
  initial begin
    port3_pin_out = 1'b0;
    alt_pin_out = 1'b0;
  end

  // set one pin just after an edge, then hold it n clocks
  task drive(input logic alt, input logic lvl, input int n);
    @(posedge clk_in);
    #1;
    if (alt) begin
      alt_pin_out = lvl;
    end else begin
      port3_pin_out = lvl;
    end
    repeat (n) @(posedge clk_in);
  endtask
endmodule

// >>> dv/tcdc_top_properties.sv
// port assertions and covers for the timer capture block
`timescale 1ns/100ps
module tcdc_chk (
  // clock and reset
  input wire clk_in,
  input wire reset_in,
  // register access
  input wire [7:0] reg_addr_in,
  input wire reg_short_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire reg_hit_out,
  input wire [7:0] map_addr_out,
  input wire [3:0] map_bank_out,
  input wire map_expanded_out,
  input wire map_valid_out,
  // timer side and pins
  input wire capture_event_out,
  input wire demod_mode_out,
  input wire [1:0] transmit_submode_out,
  input wire shared_timer_output_pin_oe_out,
  input wire interrupt_request_two_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////////////////////
  // access answer and bank mapping
  acc_valid_a: assert property ((reg_rd_in || reg_wr_in)
    |=> map_valid_out)
    else $error("access gave no mapping pulse");
  idle_data_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data without a read");
  low_bank_a: assert property (map_valid_out && !map_expanded_out
    |-> map_bank_out == 4'h0)
    else $error("bank nonzero without swap");
  swap_bank_a: assert property (map_valid_out && map_expanded_out
    |-> map_bank_out != 4'h0 && map_addr_out[7:4] == 4'h0)
    else $error("swap outside low sixteen");
  far_miss_a: assert property (reg_rd_in && !reg_short_in &&
    reg_addr_in[7:4] == 4'h4 |=> !reg_hit_out && reg_rdata_out == 8'h00)
    else $error("hit on unserved address");

  ////////////////////////////////////////////////////////////////////////////
  // mode and capture relations
  demod_sub_a: assert property (demod_mode_out
    |-> transmit_submode_out == 2'h0)
    else $error("submode shown in demodulation");
  demod_pin_a: assert property (demod_mode_out
    |-> !shared_timer_output_pin_oe_out)
    else $error("shared pin driven in demodulation");
  irq_cap_a: assert property (interrupt_request_two_out
    |-> capture_event_out)
    else $error("interrupt without capture");
  // capture and mode copy are registered from the same cycle
  cap_mode_a: assert property (capture_event_out
    |-> demod_mode_out)
    else $error("capture in transmit mode");
  cap_pulse_a: assert property (capture_event_out
    |=> !capture_event_out)
    else $error("capture pulse too long");

  // main scenarios seen
  cover property (reg_rd_in ##1 reg_hit_out);
  cover property (capture_event_out && interrupt_request_two_out);
  cover property (capture_event_out && !interrupt_request_two_out);
endmodule
